// [design/request_engine_pkg.sv]
package request_engine_pkg;

    localparam logic [15:0] ADDR_COMMAND     = 16'h004C;
    localparam logic [15:0] ADDR_INTERVAL_HI = 16'h004D;
    localparam logic [15:0] ADDR_INTERVAL_LO = 16'h004E;
    localparam logic [15:0] ADDR_LIMIT       = 16'h004F;
    localparam logic [15:0] ADDR_PEER_IP     = 16'h0050;
    localparam logic [15:0] ADDR_PEER_HW     = 16'h0054;
    localparam logic [15:0] ADDR_SEQ_HI      = 16'h005A;
    localparam logic [15:0] ADDR_SEQ_LO      = 16'h005B;
    localparam logic [15:0] ADDR_ID_HI       = 16'h005C;
    localparam logic [15:0] ADDR_ID_LO       = 16'h005D;
    localparam logic [15:0] ADDR_MASK        = 16'h005E;
    localparam logic [15:0] ADDR_FLAGS       = 16'h005F;

    localparam int CMD_PING_BIT     = 0;
    localparam int CMD_ARP_BIT      = 1;
    localparam int FLAG_PING_BIT    = 0;
    localparam int FLAG_ARP_BIT     = 1;
    localparam int FLAG_TIMEOUT_BIT = 2;

    localparam logic [1:0]  RESET_COMMAND  = 2'h0;
    localparam logic [15:0] RESET_INTERVAL = 16'h07D0;
    localparam logic [7:0]  RESET_LIMIT    = 8'h00;
    localparam logic [31:0] RESET_PEER_IP  = 32'h00000000;
    localparam logic [47:0] RESET_PEER_HW  = 48'h000000000000;
    localparam logic [15:0] RESET_SEQ      = 16'h0000;
    localparam logic [15:0] RESET_ID       = 16'h0000;
    localparam logic [2:0]  RESET_MASK     = 3'h0;
    localparam logic [2:0]  RESET_FLAGS    = 3'h0;

    // Retry interval unit and the cycle count it takes at 125 MHz
    localparam int RETRY_UNIT_NS      = 100000;
    localparam int CLOCK_PERIOD_NS    = 8;
    localparam int RETRY_UNIT_CYCLES  = RETRY_UNIT_NS / CLOCK_PERIOD_NS;

    typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WAIT} engine_state_t;

    typedef struct packed {
        engine_state_t state;
        logic [1:0]    command;
        logic [15:0]   interval;
        logic [7:0]    limit;
        logic [31:0]   peer_ip;
        logic [47:0]   peer_hw;
        logic [15:0]   seq;
        logic [15:0]   ident;
        logic [2:0]    mask;
        logic [2:0]    flags;
        logic [15:0]   tick_cnt;
        logic [15:0]   units;
        logic [7:0]    retries;
        logic          tx_arp;
        logic          tx_ping;
        logic          irq_n;
        logic [7:0]    rdata;
    } engine_regs_t;

endpackage

// [design/socketless_request_engine.sv]
`timescale 1ns/1ps
module socketless_request_engine
    import request_engine_pkg::*;
#(
    parameter int UNIT_CYCLES = RETRY_UNIT_CYCLES
) (
    input  wire logic        clock_in,
    input  wire logic        rst_n_in,
    input  wire logic        ce_in,
    input  wire logic [15:0] reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic        rx_arp_reply_in,
    input  wire logic [47:0] rx_sender_hw_in,
    input  wire logic        rx_echo_reply_in,
    input  wire logic        pend_timer_zero_in,
    output logic      [7:0]  reg_rdata_out,
    output logic             tx_arp_out,
    output logic             tx_echo_out,
    output logic      [31:0] peer_ip_out,
    output logic      [15:0] echo_seq_out,
    output logic      [15:0] echo_id_out,
    output logic             irq_out_low
);

    localparam engine_regs_t REGS_RESET = '{
        state:    ST_IDLE,
        command:  RESET_COMMAND,
        interval: RESET_INTERVAL,
        limit:    RESET_LIMIT,
        peer_ip:  RESET_PEER_IP,
        peer_hw:  RESET_PEER_HW,
        seq:      RESET_SEQ,
        ident:    RESET_ID,
        mask:     RESET_MASK,
        flags:    RESET_FLAGS,
        tick_cnt: 16'h0000,
        units:    16'h0000,
        retries:  8'h00,
        tx_arp:   1'b0,
        tx_ping:  1'b0,
        irq_n:    1'b1,
        rdata:    8'h00
    };

    logic [1:0]   rst_sync;
    logic         rst_n;
    engine_regs_t s;
    engine_regs_t next_s;
    logic [2:0]   flag_set;
    logic [2:0]   flag_clr;
    logic         unit_tick;
    logic         expire;

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    assign unit_tick = (s.tick_cnt == 16'(UNIT_CYCLES - 1));
    assign expire    = unit_tick && ((s.units + 16'h0001) >= s.interval);

    always_comb begin
        next_s         = s;
        next_s.tx_arp  = 1'b0;
        next_s.tx_ping = 1'b0;
        flag_set       = 3'h0;
        flag_clr       = 3'h0;

        if (reg_wr_in) begin
            case (reg_addr_in)
                ADDR_COMMAND: begin
                    // One command at a time, only while idle
                    if (s.command == 2'h0 && ^reg_wdata_in[1:0]) begin
                        next_s.command = reg_wdata_in[1:0];
                        next_s.state   = ST_SEND;
                        next_s.retries = 8'h00;
                    end
                end
                ADDR_INTERVAL_HI: next_s.interval[15:8] = reg_wdata_in;
                ADDR_INTERVAL_LO: next_s.interval[7:0]  = reg_wdata_in;
                ADDR_LIMIT:       next_s.limit          = reg_wdata_in;
                ADDR_SEQ_HI:      next_s.seq[15:8]      = reg_wdata_in;
                ADDR_SEQ_LO:      next_s.seq[7:0]       = reg_wdata_in;
                ADDR_ID_HI:       next_s.ident[15:8]    = reg_wdata_in;
                ADDR_ID_LO:       next_s.ident[7:0]     = reg_wdata_in;
                ADDR_MASK:        next_s.mask = reg_wdata_in[2:0];
                ADDR_FLAGS:       flag_clr    = reg_wdata_in[2:0];
                default: begin
                end
            endcase
            for (int i = 0; i < 4; i++) begin
                if (reg_addr_in == ADDR_PEER_IP + 16'(i)) begin
                    next_s.peer_ip[31 - 8 * i -: 8] = reg_wdata_in;
                end
            end
        end

        case (s.state)
            ST_IDLE: begin
                next_s.tick_cnt = 16'h0000;
            end
            ST_SEND: begin
                next_s.tx_arp   = s.command[CMD_ARP_BIT];
                next_s.tx_ping  = s.command[CMD_PING_BIT];
                next_s.tick_cnt = 16'h0000;
                next_s.units    = 16'h0000;
                next_s.state    = ST_WAIT;
            end
            ST_WAIT: begin
                next_s.tick_cnt = unit_tick ? 16'h0000
                                            : s.tick_cnt + 16'h0001;
                if (rx_arp_reply_in && s.command[CMD_ARP_BIT]) begin
                    next_s.peer_hw          = rx_sender_hw_in;
                    flag_set[FLAG_ARP_BIT]  = 1'b1;
                    next_s.command          = 2'h0;
                    next_s.state            = ST_IDLE;
                end else if (rx_echo_reply_in && s.command[CMD_PING_BIT]) begin
                    flag_set[FLAG_PING_BIT] = 1'b1;
                    next_s.command          = 2'h0;
                    next_s.state            = ST_IDLE;
                end else if (expire) begin
                    if (s.retries == s.limit) begin
                        flag_set[FLAG_TIMEOUT_BIT] = 1'b1;
                        next_s.command = 2'h0;
                        next_s.state   = ST_IDLE;
                    end else begin
                        next_s.retries = s.retries + 8'h01;
                        next_s.state   = ST_SEND;
                    end
                end else if (unit_tick) begin
                    next_s.units = s.units + 16'h0001;
                end
            end
            default: begin
                next_s.state = ST_IDLE;
            end
        endcase

        // A flag raised in the clearing cycle survives
        next_s.flags = (s.flags & ~flag_clr) | flag_set;
        next_s.irq_n = !((|(next_s.flags & next_s.mask))
                         && pend_timer_zero_in);

        next_s.rdata = 8'h00;
        if (reg_rd_in) begin
            case (reg_addr_in)
                ADDR_COMMAND:     next_s.rdata = {6'h00, s.command};
                ADDR_INTERVAL_HI: next_s.rdata = s.interval[15:8];
                ADDR_INTERVAL_LO: next_s.rdata = s.interval[7:0];
                ADDR_LIMIT:       next_s.rdata = s.limit;
                ADDR_SEQ_HI:      next_s.rdata = s.seq[15:8];
                ADDR_SEQ_LO:      next_s.rdata = s.seq[7:0];
                ADDR_ID_HI:       next_s.rdata = s.ident[15:8];
                ADDR_ID_LO:       next_s.rdata = s.ident[7:0];
                ADDR_MASK:        next_s.rdata = {5'h00, s.mask};
                ADDR_FLAGS:       next_s.rdata = {5'h00, s.flags};
                default: begin
                end
            endcase
            for (int i = 0; i < 4; i++) begin
                if (reg_addr_in == ADDR_PEER_IP + 16'(i)) begin
                    next_s.rdata = s.peer_ip[31 - 8 * i -: 8];
                end
            end
            for (int i = 0; i < 6; i++) begin
                if (reg_addr_in == ADDR_PEER_HW + 16'(i)) begin
                    next_s.rdata = s.peer_hw[47 - 8 * i -: 8];
                end
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            s <= REGS_RESET;
        end else if (ce_in) begin
            s <= next_s;
        end
    end

    assign reg_rdata_out = s.rdata;
    assign tx_arp_out    = s.tx_arp;
    assign tx_echo_out   = s.tx_ping;
    assign peer_ip_out   = s.peer_ip;
    assign echo_seq_out  = s.seq;
    assign echo_id_out   = s.ident;
    assign irq_out_low   = s.irq_n;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n);

    sequence s_cmd_write(logic [1:0] code);
        ce_in && reg_wr_in && reg_addr_in == ADDR_COMMAND
            && reg_wdata_in[1:0] == code && s.command == 2'h0;
    endsequence

    sequence s_waiting(int bit_idx);
        ce_in && s.state == ST_WAIT && s.command[bit_idx];
    endsequence

    a_arp_start: assert property (
        s_cmd_write(2'b10) ##1 ce_in |=> tx_arp_out && !tx_echo_out)
        else $error("ARP command did not send one ARP request");

    a_echo_start: assert property (
        s_cmd_write(2'b01) ##1 ce_in |=> tx_echo_out && !tx_arp_out)
        else $error("Echo command did not send one echo request");

    a_arp_capture: assert property (
        s_waiting(CMD_ARP_BIT) and rx_arp_reply_in
        |=> s.command == 2'h0 && s.flags[FLAG_ARP_BIT]
            && s.peer_hw == $past(rx_sender_hw_in))
        else $error("ARP reply not captured or command not cleared");

    a_echo_done: assert property (
        s_waiting(CMD_PING_BIT) and rx_echo_reply_in
        |=> s.command == 2'h0 && s.flags[FLAG_PING_BIT]
            && s.state == ST_IDLE)
        else $error("Echo reply did not end the request");

    a_timeout_raise: assert property (
        ce_in && s.state == ST_WAIT && expire && s.retries == s.limit
            && !rx_arp_reply_in && !rx_echo_reply_in
        |=> s.flags[FLAG_TIMEOUT_BIT] && s.command == 2'h0)
        else $error("Timeout flag not raised at retry limit");

    a_retry_resend: assert property (
        ce_in && s.state == ST_WAIT && expire && s.retries != s.limit
            && !rx_arp_reply_in && !rx_echo_reply_in ##1 ce_in
        |=> tx_arp_out || tx_echo_out)
        else $error("No resend after retry interval");

    a_irq_level: assert property (
        ce_in |=> irq_out_low == !((|(s.flags & s.mask))
                                   && $past(pend_timer_zero_in)))
        else $error("Interrupt pin does not follow flags and mask");

    a_flag_clear: assert property (
        ce_in && reg_wr_in && reg_addr_in == ADDR_FLAGS
            && reg_wdata_in[FLAG_TIMEOUT_BIT]
            && !flag_set[FLAG_TIMEOUT_BIT]
        |=> !s.flags[FLAG_TIMEOUT_BIT]
            && irq_out_low == !((|(s.flags & s.mask))
                                && $past(pend_timer_zero_in)))
        else $error("Writing one did not clear the timeout flag");

    a_seq_stable: assert property (
        !(reg_wr_in && (reg_addr_in == ADDR_SEQ_HI
                        || reg_addr_in == ADDR_SEQ_LO))
        |=> $stable(echo_seq_out))
        else $error("Echo sequence changed without a write");

    a_id_stable: assert property (
        !(reg_wr_in && (reg_addr_in == ADDR_ID_HI
                        || reg_addr_in == ADDR_ID_LO))
        |=> $stable(echo_id_out))
        else $error("Echo identifier changed without a write");

    a_ip_stable: assert property (
        !(reg_wr_in && reg_addr_in[15:2] == ADDR_PEER_IP[15:2])
        |=> $stable(peer_ip_out))
        else $error("Peer address changed without a write");

    a_hw_hold: assert property (
        !(ce_in && s.state == ST_WAIT && s.command[CMD_ARP_BIT]
          && rx_arp_reply_in)
        |=> $stable(s.peer_hw))
        else $error("Peer hardware address changed without a reply");

    a_pulse_once: assert property (
        ce_in && (tx_arp_out || tx_echo_out)
        |=> !tx_arp_out && !tx_echo_out)
        else $error("Request pulse lasted more than one cycle");

    a_tx_exclusive: assert property (
        !(tx_arp_out && tx_echo_out))
        else $error("ARP and echo requests sent together");

    a_cmd_refused: assert property (
        ce_in && reg_wr_in && reg_addr_in == ADDR_COMMAND
            && s.state == ST_IDLE && !(^reg_wdata_in[1:0])
        |=> s.command == 2'h0 && s.state == ST_IDLE)
        else $error("Command with no or both bits was accepted");

    a_mask_release: assert property (
        ce_in && reg_wr_in && reg_addr_in == ADDR_MASK
            && reg_wdata_in[2:0] == 3'h0
        |=> irq_out_low)
        else $error("Interrupt pin stayed low with all masks off");

    a_flag_keep: assert property (
        ce_in && reg_wr_in && reg_addr_in == ADDR_FLAGS
            && reg_wdata_in[2:0] == 3'h0
        |=> s.flags == ($past(s.flags) | $past(flag_set)))
        else $error("Writing zero changed a flag");

    a_stray_reply: assert property (
        ce_in && s.state == ST_IDLE
            && (rx_arp_reply_in || rx_echo_reply_in)
            && !(reg_wr_in && reg_addr_in == ADDR_FLAGS)
        |=> s.flags == $past(s.flags))
        else $error("Reply outside a request raised a flag");

    a_cmd_read: assert property (
        ce_in && reg_rd_in && reg_addr_in == ADDR_COMMAND
        |=> reg_rdata_out == {6'h00, $past(s.command)})
        else $error("Command read back wrong");

    a_ip_read: assert property (
        ce_in && reg_rd_in && reg_addr_in == ADDR_PEER_IP
        |=> reg_rdata_out == $past(s.peer_ip[31:24]))
        else $error("First peer address octet read back wrong");

    a_hw_read: assert property (
        ce_in && reg_rd_in && reg_addr_in == ADDR_PEER_HW
        |=> reg_rdata_out == $past(s.peer_hw[47:40]))
        else $error("First hardware octet read back wrong");

    a_seq_read: assert property (
        ce_in && reg_rd_in && reg_addr_in == ADDR_SEQ_HI
        |=> reg_rdata_out == $past(s.seq[15:8]))
        else $error("Echo sequence high byte read back wrong");

endmodule

// [verification/remote_node.sv]
`timescale 1ns/1ps
module remote_node #(
    parameter logic [47:0] HW_ADDR = 48'h0A1B2C3D4E5F
) (
    input  wire logic        clock_in,
    input  wire logic        tx_arp_in,
    input  wire logic        tx_echo_in,
    input  wire logic        answer_in,
    input  wire logic [3:0]  delay_in,
    output logic             arp_reply_out,
    output logic      [47:0] sender_hw_out,
    output logic             echo_reply_out
);
    logic is_arp;
    initial begin
        arp_reply_out  = 1'b0;
        echo_reply_out = 1'b0;
        sender_hw_out  = ~HW_ADDR;
    end
    // Serves one request at a time; a resend seen while busy goes unanswered
    always @(negedge clock_in) begin
        if ((tx_arp_in === 1'b1 || tx_echo_in === 1'b1) && answer_in) begin
            is_arp = tx_arp_in;
            repeat (delay_in) @(posedge clock_in);
            @(negedge clock_in);
            arp_reply_out  = is_arp;
            echo_reply_out = !is_arp;
            sender_hw_out  = is_arp ? HW_ADDR : ~HW_ADDR;
            @(negedge clock_in);
            arp_reply_out  = 1'b0;
            echo_reply_out = 1'b0;
            sender_hw_out  = ~HW_ADDR;
        end
    end
endmodule

// [verification/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    import request_engine_pkg::*;
    localparam logic [47:0] HW = 48'h0A1B2C3D4E5F;
    logic        clock_in = 1'b0, rst_n_in = 1'b0;
    logic [15:0] reg_addr_in = 16'h0000;
    logic [7:0]  reg_wdata_in = 8'h00;
    logic        reg_wr_in = 1'b0, reg_rd_in = 1'b0, pend_timer_zero_in = 1'b1;
    logic        answer = 1'b0;
    logic        ce = 1'b1;
    logic [3:0]  delay = 4'h2;
    logic        rx_arp, rx_echo, tx_arp_out, tx_echo_out, irq_out_low;
    logic [47:0] rx_hw;
    logic [7:0]  reg_rdata_out;
    logic [31:0] peer_ip_out;
    logic [15:0] echo_seq_out, echo_id_out;
    int          num_errors = 0, check_count = 0;
    int          arp_count = 0, echo_count = 0;
    socketless_request_engine #(.UNIT_CYCLES(8)) socketless_request_engine_inst (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .ce_in(ce),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .rx_arp_reply_in(rx_arp), .rx_sender_hw_in(rx_hw),
        .rx_echo_reply_in(rx_echo), .pend_timer_zero_in(pend_timer_zero_in),
        .reg_rdata_out(reg_rdata_out), .tx_arp_out(tx_arp_out),
        .tx_echo_out(tx_echo_out), .peer_ip_out(peer_ip_out),
        .echo_seq_out(echo_seq_out), .echo_id_out(echo_id_out),
        .irq_out_low(irq_out_low));
    remote_node #(.HW_ADDR(HW)) remote_node_inst (
        .clock_in(clock_in), .tx_arp_in(tx_arp_out), .tx_echo_in(tx_echo_out),
        .answer_in(answer), .delay_in(delay), .arp_reply_out(rx_arp),
        .sender_hw_out(rx_hw), .echo_reply_out(rx_echo));
    initial forever #4 clock_in = ~clock_in;
    always @(negedge clock_in) begin
        if (tx_arp_out === 1'b1) arp_count++;
        if (tx_echo_out === 1'b1) echo_count++;
    end
    task automatic check_val(input string name, input logic [47:0] exp,
                             input logic [47:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic reg_write(input logic [15:0] addr, input logic [7:0] data);
        @(negedge clock_in);
        reg_addr_in  = addr;
        reg_wdata_in = data;
        reg_wr_in    = 1'b1;
        @(negedge clock_in);
        reg_wr_in = 1'b0;
    endtask
    task automatic reg_check(input logic [15:0] addr, input logic [7:0] exp);
        @(negedge clock_in);
        reg_addr_in = addr;
        reg_rd_in   = 1'b1;
        @(negedge clock_in);
        reg_rd_in = 1'b0;
        check_val($sformatf("reg %h", addr), exp, reg_rdata_out);
    endtask
    task automatic wait_irq_low(input int limit);
        for (int i = 0; i < limit && irq_out_low !== 1'b0; i++)
            @(negedge clock_in);
    endtask
    task automatic test_reset_values();
        logic [7:0] want;
        for (int a = 16'h4C; a <= 16'h60; a++) begin
            want = 8'h00;
            if (a == 16'h4D) begin
                want = 8'h07;
            end
            if (a == 16'h4E) begin
                want = 8'hD0;
            end
            reg_check(a[15:0], want);
        end
        check_val("irq", 1, irq_out_low);
    endtask
    task automatic test_config();
        reg_write(16'h50, 8'hC0);
        reg_write(16'h51, 8'hA8);
        reg_write(16'h52, 8'h00);
        reg_write(16'h53, 8'h15);
        reg_write(ADDR_SEQ_HI, 8'h03);
        reg_write(ADDR_SEQ_LO, 8'hE8);
        reg_write(ADDR_ID_HI, 8'h01);
        reg_write(ADDR_ID_LO, 8'h00);
        reg_write(ADDR_PEER_HW, 8'h5A);
        check_val("ip", 32'hC0A80015, peer_ip_out);
        check_val("seq", 16'h03E8, echo_seq_out);
        check_val("id", 16'h0100, echo_id_out);
        reg_check(16'h50, 8'hC0);
        reg_check(ADDR_SEQ_HI, 8'h03);
        reg_check(ADDR_ID_HI, 8'h01);
        reg_check(ADDR_PEER_HW, 8'h00);
        arp_count = 0;
        echo_count = 0;
        reg_write(ADDR_COMMAND, 8'h03);
        repeat (20) @(negedge clock_in);
        check_val("both bits refused", 0, arp_count + echo_count);
        reg_check(ADDR_COMMAND, 8'h00);
    endtask
    task automatic test_arp(input logic [3:0] dly, input int sends);
        answer = 1'b1;
        delay = dly;
        arp_count = 0;
        reg_write(ADDR_INTERVAL_HI, 8'h00);
        reg_write(ADDR_INTERVAL_LO, 8'h01);
        reg_write(ADDR_LIMIT, 8'h03);
        reg_write(ADDR_MASK, 8'h02);
        reg_write(ADDR_COMMAND, 8'h02);
        reg_check(ADDR_COMMAND, 8'h02);
        wait_irq_low(200);
        check_val("irq arp", 0, irq_out_low);
        check_val("arp sends", sends, arp_count);
        reg_check(ADDR_FLAGS, 8'h02);
        reg_check(ADDR_COMMAND, 8'h00);
        for (int i = 0; i < 6; i++)
            reg_check(ADDR_PEER_HW + 16'(i), HW[47 - 8 * i -: 8]);
        reg_write(ADDR_FLAGS, 8'h01);
        reg_check(ADDR_FLAGS, 8'h02);
        reg_write(ADDR_FLAGS, 8'h02);
        reg_check(ADDR_FLAGS, 8'h00);
        check_val("irq cleared", 1, irq_out_low);
        answer = 1'b0;
    endtask
    task automatic test_echo_timeout();
        echo_count = 0;
        reg_write(ADDR_LIMIT, 8'h02);
        reg_write(ADDR_MASK, 8'h04);
        reg_write(ADDR_COMMAND, 8'h01);
        wait_irq_low(300);
        check_val("irq timeout", 0, irq_out_low);
        check_val("echo sends", 3, echo_count);
        reg_check(ADDR_FLAGS, 8'h04);
        reg_check(ADDR_COMMAND, 8'h00);
        check_val("seq kept", 16'h03E8, echo_seq_out);
        reg_write(ADDR_MASK, 8'h03);
        check_val("irq masked", 1, irq_out_low);
        reg_write(ADDR_MASK, 8'h04);
        check_val("irq unmasked", 0, irq_out_low);
        pend_timer_zero_in = 1'b0;
        @(negedge clock_in);
        check_val("irq pending", 1, irq_out_low);
        pend_timer_zero_in = 1'b1;
        reg_write(ADDR_FLAGS, 8'h04);
        // A write while the enable is low must not land
        ce = 1'b0;
        reg_write(ADDR_LIMIT, 8'h55);
        ce = 1'b1;
        reg_check(ADDR_LIMIT, 8'h02);
    endtask
    task automatic test_echo_reply();
        answer = 1'b1;
        delay = 4'h2;
        echo_count = 0;
        reg_write(ADDR_MASK, 8'h01);
        reg_write(ADDR_COMMAND, 8'h01);
        wait_irq_low(200);
        check_val("irq echo", 0, irq_out_low);
        check_val("echo sends", 1, echo_count);
        reg_check(ADDR_FLAGS, 8'h01);
        check_val("id kept", 16'h0100, echo_id_out);
    endtask
    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (3) @(negedge clock_in);
        rst_n_in = 1'b1;
        repeat (3) @(negedge clock_in);
        test_reset_values();
        test_config();
        test_arp(4'h2, 1);
        test_arp(4'hC, 2);
        test_echo_timeout();
        test_echo_reply();
        end_of_test();
    end
endmodule
